/* File: common/sfb_cfg.svh */
`ifndef SFB_CFG_SVH
`define SFB_CFG_SVH

// Command bytes
`define SFB_CMD_READ   8'hff
`define SFB_CMD_PROG   8'h41
`define SFB_CMD_ERASE  8'ha7
`define SFB_CMD_CONF   8'hd0
`define SFB_CMD_STAT   8'h70
`define SFB_CMD_CLR    8'h50
`define SFB_CMD_ID     8'hf5
`define SFB_CMD_LOAD   8'hfa
`define SFB_CMD_VER    8'hfb
`define SFB_CMD_BOOT   8'hfc

// Main status bit positions
`define SFB_SR_READY   7
`define SFB_SR_ERASE   5
`define SFB_SR_PROG    4
`define SFB_SR_THREE   3

// Extended status bit positions
`define SFB_XS_UPD     7
`define SFB_XS_CKM     4
`define SFB_XS_ID_HI   3
`define SFB_XS_ID_LO   2

// Identity check results
`define SFB_ID_NONE    2'h0
`define SFB_ID_BAD     2'h1
`define SFB_ID_OK      2'h3

// Counts
`define SFB_ID_LEN     8'h07
`define SFB_VER_LEN    4'h8
`define SFB_PAGE_LAST  8'hff

// Version text, eight characters, first one in the low byte (arbitrary)
`define SFB_VERSION    64'h30302e3120524556

`endif

/* File: common/sfb_pkg.sv */
package sfb_pkg;

    typedef enum logic [2:0] {
        st_cmd  = 3'h0,
        st_args = 3'h1,
        st_out  = 3'h3,
        st_in   = 3'h2,
        st_work = 3'h6
    } sfb_state_e;

    typedef struct packed {
        logic [7:0] sh;
        logic [7:0] rx;
        logic [2:0] cnt;
        logic       tgl;
        logic       fr;
    } sfb_link_s;

    typedef struct packed {
        sfb_state_e  st;
        logic [7:0]  cmd;
        logic [3:0]  pos;
        logic [15:0] size;
        logic [15:0] addr;
        logic [7:0]  sum;
        logic [7:0]  csum;
        logic [7:0]  idsz;
        logic [7:0]  tx;
        logic [7:0]  wdata;
        logic [1:0]  idst;
        logic        id_ok;
        logic        busy;
        logic        rd_wait;
        logic        mem_rd;
        logic        mem_wr;
        logic        erase_go;
        logic        ram_we;
        logic        exec_go;
        logic        erase_err;
        logic        prog_err;
        logic        upd;
        logic        ckm;
        logic        t1;
        logic        t2;
        logic        t3;
        logic        f1;
        logic        f2;
    } sfb_core_s;

endpackage : sfb_pkg

/* File: hdl/sfb_link.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sfb_cfg.svh"

module sfb_link
    import sfb_pkg::*;
(
    // Link pins
    input  wire logic       sclk,
    input  wire logic       reset_n,
    input  wire logic       rxd,
    output logic            txd,
    // Core side
    input  wire logic [7:0] tx_data,
    output logic [7:0]      rx_byte,
    output logic            rx_tgl,
    output logic            in_frame
);

    sfb_link_s r_reg;
    sfb_link_s r_next;
    logic      txd_reg;

    // Receive shifter
    always_comb begin
        r_next     = r_reg;
        r_next.sh  = {rxd, r_reg.sh[7:1]};                       // R18
        r_next.cnt = r_reg.cnt + 3'h1;
        if (r_reg.cnt == 3'h7) begin
            r_next.rx  = {rxd, r_reg.sh[7:1]};
            r_next.tgl = ~r_reg.tgl;
        end
        r_next.fr  = (r_next.cnt != 3'h0);
    end

    always_ff @(posedge sclk or negedge reset_n) begin           // R19
        if (!reset_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // Transmit bit changes on the falling edge
    always_ff @(negedge sclk or negedge reset_n) begin           // R19
        if (!reset_n) begin
            txd_reg <= 1'b1;
        end else begin
            txd_reg <= tx_data[r_reg.cnt];                       // R18
        end
    end

    // Bit 0 of the held byte stands before the first edge
    assign txd      = (r_reg.cnt == 3'h0) ? tx_data[0] : txd_reg;
    assign rx_byte  = r_reg.rx;
    assign rx_tgl   = r_reg.tgl;
    assign in_frame = r_reg.fr;

endmodule : sfb_link

`default_nettype wire

/* File: hdl/sfb_core.sv */
// What this block does
// R1 - Command ff plus address returns the 256-byte flash page from byte four.
// R2 - Command 41, address, then 256 data bytes are written to the page.
// R3 - After a page program, ready/busy drops once ready for the next page.
// R4 - Command a7 starts the full erase only when followed by d0.
// R5 - Ready/busy drops when the full erase has completed.
// R6 - Command 70 returns main status then extended status.
// R7 - Command 50 clears the error status bits three to five.
// R8 - Ready/busy drops when the status clear is done.
// R9 - Command f5 carries address, size and seven identity bytes compared to stored code.
// R10 - Non-blank flash takes only status, identity and version before identity match.
// R11 - Command fa carries size, checksum, then program bytes summed from byte five.
// R12 - The downloaded program starts only when the checksum matches.
// R13 - Command fb returns eight version characters from byte two.
// R14 - Command fc plus address returns the boot area page from byte four.
// R15 - The programmer sends addresses low, middle, high with high byte zero.
// R16 - The programmer sends every command on the receive line.
// R17 - No single block erase command exists in this mode.
// R18 - Every transfer is eight bits, least significant bit first.
// R19 - Input sampled on rising transfer clock, output changed on falling edge.
// R20 - Ready/busy is high while transferring or working; programmer waits for low.
// R21 - Gated commands are refused on filled flash until the identity matched.
// R22 - Unknown or refused command bytes are dropped; wait for the next command.
// R23 - The byte position in each command decides each byte's meaning.
`timescale 1ns/1ns
`default_nettype none
`include "sfb_cfg.svh"

module sfb_core
    import sfb_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Serial link
    input  wire logic        sclk,
    input  wire logic        rxd,
    output logic             txd,
    output logic             busy,
    // Flash array
    input  wire logic        flash_blank,
    output logic [15:0]      mem_addr,
    output logic             mem_boot,
    output logic             mem_rd,
    input  wire logic [7:0]  mem_rdata,
    output logic             mem_wr,
    output logic [7:0]       mem_wdata,
    output logic             erase_start,
    input  wire logic        op_done,
    input  wire logic        op_error,
    input  wire logic [55:0] id_code,
    // Download memory
    output logic [15:0]      ram_addr,
    output logic             ram_we,
    output logic [7:0]       ram_wdata,
    output logic             exec_start
);

    sfb_core_s  r;
    sfb_core_s  n;
    logic [7:0] rx_byte;
    logic       rx_tgl;
    logic       in_frame;
    logic       rx_ev;
    logic       cmd_open;
    logic [7:0] main_flash_status;
    logic [7:0] extended_link_status;

    sfb_link u_link (
        .sclk     (sclk),
        .reset_n  (reset_n),
        .rxd      (rxd),
        .txd      (txd),
        .tx_data  (r.tx),
        .rx_byte  (rx_byte),
        .rx_tgl   (rx_tgl),
        .in_frame (in_frame)
    );

    assign rx_ev = r.t2 ^ r.t3;

    // Commands allowed before identity match
    assign cmd_open = flash_blank || (r.idst == `SFB_ID_OK)        // R10 R21
                      || (rx_byte == `SFB_CMD_STAT)
                      || (rx_byte == `SFB_CMD_ID)
                      || (rx_byte == `SFB_CMD_VER);

    // Status bytes
    always_comb begin
        main_flash_status                  = 8'h00;
        main_flash_status[`SFB_SR_READY]   = (r.st != st_work);
        main_flash_status[`SFB_SR_ERASE]   = r.erase_err;
        main_flash_status[`SFB_SR_PROG]    = r.prog_err;
        extended_link_status               = 8'h00;
        extended_link_status[`SFB_XS_UPD]  = r.upd;
        extended_link_status[`SFB_XS_CKM]  = r.ckm;
        extended_link_status[`SFB_XS_ID_HI:`SFB_XS_ID_LO] = r.idst;
    end

    always_comb begin
        n          = r;
        n.mem_rd   = 1'b0;
        n.mem_wr   = 1'b0;
        n.erase_go = 1'b0;
        n.ram_we   = 1'b0;
        n.exec_go  = 1'b0;
        n.t1       = rx_tgl;
        n.t2       = r.t1;
        n.t3       = r.t2;
        n.f1       = in_frame;
        n.f2       = r.f1;
        // Step the address after each write
        if (r.mem_wr || r.ram_we) begin
            n.addr = r.addr + 16'h1;
        end
        // Read data arrives one cycle after the strobe
        if (r.rd_wait && !r.mem_rd) begin
            n.rd_wait = 1'b0;
            n.tx      = mem_rdata;                               // R1 R14
            n.busy    = 1'b0;
        end
        if (r.st == st_work) begin
            if (r.cmd == `SFB_CMD_CLR) begin
                n.busy = 1'b0;                                   // R8
                n.st   = st_cmd;
            end else if (op_done) begin
                if (r.cmd == `SFB_CMD_ERASE) begin
                    n.erase_err = op_error;
                end else begin
                    n.prog_err = r.prog_err | op_error;
                end
                n.busy = 1'b0;                                   // R3 R5
                n.st   = st_cmd;
            end
        end
        if (rx_ev) begin
            n.busy = 1'b1;                                       // R20
            n.pos  = r.pos + 4'h1;                               // R23
            unique case (r.st)
                st_cmd: begin
                    n.cmd  = rx_byte;
                    n.pos  = 4'h1;
                    n.busy = 1'b0;
                    if (cmd_open) begin
                        case (rx_byte)                           // R17
                            `SFB_CMD_READ, `SFB_CMD_PROG, `SFB_CMD_BOOT,
                            `SFB_CMD_LOAD, `SFB_CMD_ID, `SFB_CMD_ERASE: begin
                                n.st = st_args;
                            end
                            `SFB_CMD_STAT: begin
                                n.st = st_out;
                                n.tx = main_flash_status;        // R6
                            end
                            `SFB_CMD_VER: begin
                                n.st = st_out;
                                n.tx = 8'(`SFB_VERSION);         // R13
                            end
                            `SFB_CMD_CLR: begin
                                n.erase_err = 1'b0;              // R7
                                n.prog_err  = 1'b0;
                                n.busy      = 1'b1;
                                n.st        = st_work;
                            end
                            default: begin
                                n.st = st_cmd;                   // R22
                            end
                        endcase
                    end
                end
                st_args: begin
                    n.busy = 1'b0;
                    case (r.cmd)
                        `SFB_CMD_ERASE: begin
                            if (rx_byte == `SFB_CMD_CONF) begin
                                n.erase_go = 1'b1;               // R4
                                n.busy     = 1'b1;
                                n.st       = st_work;
                            end else begin
                                n.st = st_cmd;                   // R22
                            end
                        end
                        `SFB_CMD_LOAD: begin                     // R11
                            if (r.pos == 4'h1) begin
                                n.size[7:0] = rx_byte;
                            end else if (r.pos == 4'h2) begin
                                n.size[15:8] = rx_byte;
                            end else begin
                                n.csum = rx_byte;
                                n.sum  = 8'h00;
                                n.addr = 16'h0000;
                                n.st   = (r.size == 16'h0000) ? st_cmd : st_in;
                            end
                        end
                        `SFB_CMD_ID: begin                       // R9
                            if (r.pos == 4'h4) begin
                                n.idsz  = rx_byte;
                                n.id_ok = (rx_byte == `SFB_ID_LEN);
                                n.addr  = 16'h0000;
                                n.st    = st_in;
                                if (rx_byte == 8'h00) begin
                                    n.idst = `SFB_ID_BAD;
                                    n.st   = st_cmd;
                                end
                            end
                        end
                        default: begin                           // R1 R2 R14
                            if (r.pos == 4'h1) begin
                                n.addr = {rx_byte, 8'h00};
                            end else if (r.cmd == `SFB_CMD_PROG) begin
                                n.st = st_in;
                            end else begin
                                n.st      = st_out;
                                n.mem_rd  = 1'b1;
                                n.rd_wait = 1'b1;
                                n.busy    = 1'b1;
                            end
                        end
                    endcase
                end
                st_out: begin
                    n.busy = 1'b0;
                    case (r.cmd)
                        `SFB_CMD_STAT: begin                     // R6
                            if (r.pos == 4'h1) begin
                                n.tx = extended_link_status;
                            end else begin
                                n.st = st_cmd;
                            end
                        end
                        `SFB_CMD_VER: begin                      // R13
                            if (r.pos < `SFB_VER_LEN) begin
                                n.tx = 8'(`SFB_VERSION >> {r.pos, 3'h0});
                            end else begin
                                n.st = st_cmd;
                            end
                        end
                        default: begin                           // R1 R14
                            if (r.addr[7:0] == `SFB_PAGE_LAST) begin
                                n.st = st_cmd;
                            end else begin
                                n.addr    = r.addr + 16'h1;
                                n.mem_rd  = 1'b1;
                                n.rd_wait = 1'b1;
                                n.busy    = 1'b1;
                            end
                        end
                    endcase
                end
                st_in: begin
                    n.busy = 1'b0;
                    case (r.cmd)
                        `SFB_CMD_PROG: begin                     // R2
                            n.mem_wr = 1'b1;
                            n.wdata  = rx_byte;
                            if (r.addr[7:0] == `SFB_PAGE_LAST) begin
                                n.busy = 1'b1;
                                n.st   = st_work;
                            end
                        end
                        `SFB_CMD_LOAD: begin                     // R11
                            n.ram_we = 1'b1;
                            n.wdata  = rx_byte;
                            n.sum    = r.sum + rx_byte;
                            if ((r.addr + 16'h1) == r.size) begin
                                n.ckm     = (n.sum == r.csum);   // R12
                                n.exec_go = (n.sum == r.csum);
                                n.upd     = r.upd | (n.sum == r.csum);
                                n.st      = st_cmd;
                            end
                        end
                        default: begin                           // R9
                            n.addr = r.addr + 16'h1;
                            if (r.addr >= 16'h0007) begin
                                n.id_ok = 1'b0;
                            end else if (rx_byte != id_code[{r.addr[2:0], 3'h0} +: 8]) begin
                                n.id_ok = 1'b0;
                            end
                            if ((r.addr[7:0] + 8'h1) == r.idsz) begin
                                n.idst = (n.id_ok && r.addr[15:8] == 8'h00)
                                         ? `SFB_ID_OK : `SFB_ID_BAD;
                                n.st   = st_cmd;
                            end
                        end
                    endcase
                end
                st_work: begin
                    n.busy = r.busy && (n.st == st_work);
                end
                default: begin
                    n.st   = st_cmd;
                    n.busy = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign busy        = r.busy | r.f2 | rx_ev;                  // R20
    assign mem_addr    = r.addr;
    assign mem_boot    = (r.cmd == `SFB_CMD_BOOT);               // R14
    assign mem_rd      = r.mem_rd;
    assign mem_wr      = r.mem_wr;
    assign mem_wdata   = r.wdata;
    assign erase_start = r.erase_go;
    assign ram_addr    = r.addr;
    assign ram_we      = r.ram_we;
    assign ram_wdata   = r.wdata;
    assign exec_start  = r.exec_go;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_clear_cmd;
        rx_ev && r.st == st_cmd && rx_byte == `SFB_CMD_CLR && cmd_open;
    endsequence

    sequence s_flags_gone;
        main_flash_status[5:3] == 3'h0 ##1 !r.busy;
    endsequence

    chk_erase_confirm: assert property ( // R4
        r.erase_go |-> $past(rx_byte) == `SFB_CMD_CONF && r.cmd == `SFB_CMD_ERASE)
        else $error("erase started without confirmation byte");

    chk_erase_ready: assert property ( // R5
        (r.st == st_work && r.cmd == `SFB_CMD_ERASE && op_done)
        |=> !r.busy && r.st == st_cmd)
        else $error("busy not dropped after erase");

    chk_prog_ready: assert property ( // R3
        (r.st == st_work && r.cmd == `SFB_CMD_PROG && op_done)
        |=> !r.busy && r.st == st_cmd)
        else $error("busy not dropped after page program");

    chk_clear_flags: assert property ( // R7
        s_clear_cmd |=> s_flags_gone)
        else $error("error flags not cleared");

    chk_exec_match: assert property ( // R12
        r.exec_go |-> r.ckm && r.upd && r.sum == r.csum)
        else $error("execution without checksum match");

    chk_gate_lock: assert property ( // R10
        (rx_ev && r.st == st_cmd && !flash_blank && r.idst != `SFB_ID_OK
         && rx_byte == `SFB_CMD_READ) |=> r.st == st_cmd && !r.busy)
        else $error("gated command accepted while locked");

    chk_stat_byte: assert property ( // R6
        (rx_ev && r.st == st_cmd && rx_byte == `SFB_CMD_STAT)
        |=> r.tx == main_flash_status && r.st == st_out)
        else $error("status byte not loaded");

    chk_read_fetch: assert property ( // R1
        r.mem_rd |-> ##2 (r.tx == $past(mem_rdata) && !r.busy))
        else $error("read data not presented");

endmodule : sfb_core

`default_nettype wire

/* File: test/sfb_prog.sv */
`timescale 1ns/1ns
`default_nettype none

module sfb_prog (
    // Link lines
    output logic      sclk,
    output logic      rxd,
    input  wire logic txd,
    input  wire logic busy
);
    initial begin
        sclk = 1'b1;
        rxd  = 1'b1;
    end

    // One byte each way, then wait for ready
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        int n;
        for (int i = 0; i < 8; i++) begin
            sclk = 1'b0;
            rxd  = d[i];
            #32 q[i] = txd;
            sclk = 1'b1;
            #32;
        end
        rxd = ~rxd;
        n   = 0;
        #200;
        while (busy !== 1'b0 && n < 20000) begin
            #40 n++;
        end
    endtask : xfer
endmodule : sfb_prog

`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sfb_cfg.svh"

module tb;
    logic        clk, reset_n, sclk, rxd, txd, busy, flash_blank, mem_boot, mem_rd, mem_wr;
    logic        erase_start, op_done, op_error, ram_we, exec_start;
    logic [15:0] mem_addr, ram_addr;
    logic [7:0]  mem_rdata, mem_wdata, ram_wdata;
    logic [55:0] id_code;
    int          errors, samples_checked, n_wr, bad_wr, n_ram, n_exec, n_erase, n_rd, dcnt;

    sfb_core i_dut (.clk(clk), .reset_n(reset_n), .sclk(sclk), .rxd(rxd), .txd(txd),
        .busy(busy), .flash_blank(flash_blank), .mem_addr(mem_addr), .mem_boot(mem_boot),
        .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .erase_start(erase_start), .op_done(op_done), .op_error(op_error),
        .id_code(id_code), .ram_addr(ram_addr), .ram_we(ram_we), .ram_wdata(ram_wdata),
        .exec_start(exec_start));

    sfb_prog i_prog (.sclk(sclk), .rxd(rxd), .txd(txd), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Flash array and download memory model
    always @(posedge clk) begin
        if (mem_rd) mem_rdata <= #1 mem_addr[7:0] + mem_addr[15:8] + {7'h0, mem_boot};
        n_rd    <= n_rd + int'(mem_rd);
        n_wr    <= n_wr + int'(mem_wr);
        bad_wr  <= bad_wr + int'(mem_wr && (mem_wdata !== mem_addr[7:0] + 8'h11
                   || mem_addr[15:8] !== 8'h02))
                   + int'(ram_we && (ram_addr[15:1] !== 15'h0
                   || ram_wdata !== (ram_addr[0] ? 8'h34 : 8'h12)));
        n_ram   <= n_ram + int'(ram_we);
        n_exec  <= n_exec + int'(exec_start);
        n_erase <= n_erase + int'(erase_start);
        op_done <= #1 (dcnt == 1);
        dcnt    <= #1 (erase_start || (mem_wr && mem_addr[7:0] == 8'hff)) ? 30
                   : (dcnt > 0 ? dcnt - 1 : 0);
    end

    task automatic check(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : check

    task automatic snd(input logic [7:0] d);
        logic [7:0] q;
        i_prog.xfer(d, q);
    endtask : snd

    task automatic stat(input logic [7:0] m, input logic [7:0] x);
        logic [7:0] q;
        snd(8'h70);
        i_prog.xfer(8'h00, q);
        check(q === m, "main status");
        i_prog.xfer(8'h00, q);
        check(q === x, "extended status");
    endtask : stat

    task automatic t_refuse;
        logic [7:0] c [7] = '{8'hff, 8'h41, 8'ha7, 8'h50, 8'hfa, 8'hfc, 8'h20};
        int r0;
        r0 = n_rd;
        foreach (c[i]) snd(c[i]);
        check(n_rd === r0 && n_erase === 0, "gated command ran");
        stat(8'h80, 8'h00);
        flash_blank = 1'b1;
        snd(8'ha7);
        snd(8'hd0);
        check(n_erase === 1, "blank flash erase refused");
        flash_blank = 1'b0;
    endtask : t_refuse

    task automatic t_version;
        logic [7:0] q;
        snd(8'hfb);
        for (int i = 0; i < 8; i++) begin
            i_prog.xfer(8'h00, q);
            check(q === 8'(`SFB_VERSION >> (8 * i)), "version text");
        end
    endtask : t_version

    task automatic t_id(input logic [7:0] b1, input logic [7:0] x);
        logic [7:0] s [5] = '{8'hf5, 8'hd4, 8'hff, 8'h00, 8'h07};
        foreach (s[i]) snd(s[i]);
        snd(b1);
        for (int i = 1; i < 7; i++) snd(id_code[8*i +: 8]);
        stat(8'h80, x);
    endtask : t_id

    task automatic t_read(input logic [7:0] c, input logic [7:0] pg);
        logic [7:0] q;
        snd(c);
        snd(pg);
        snd(8'h00);
        for (int i = 0; i < 256; i++) begin
            i_prog.xfer(8'h00, q);
            check(q === 8'(i) + pg + 8'(c == 8'hfc), "page data");
        end
        check(mem_boot === 1'b0 || c == 8'hfc, "area select");
        stat(8'h80, 8'h0c);
    endtask : t_read

    task automatic t_prog;
        int w0;
        w0 = n_wr;
        op_error = 1'b1;
        snd(8'h41);
        snd(8'h02);
        snd(8'h00);
        for (int i = 0; i < 256; i++) snd(8'(i) + 8'h11);
        check(n_wr - w0 === 256 && bad_wr === 0, "page write");
        check(busy === 1'b0, "ready after page");
        stat(8'h90, 8'h0c);
        op_error = 1'b0;
        snd(8'h50);
        check(busy === 1'b0, "ready after clear");
        stat(8'h80, 8'h0c);
    endtask : t_prog

    task automatic t_erase;
        snd(8'ha7);
        snd(8'h00);
        check(n_erase === 1, "erase without confirm");
        op_error = 1'b1;
        snd(8'ha7);
        snd(8'hd0);
        op_error = 1'b0;
        check(n_erase === 2 && busy === 1'b0, "erase all");
        stat(8'ha0, 8'h0c);
        snd(8'h50);
        stat(8'h80, 8'h0c);
    endtask : t_erase

    task automatic t_load(input logic [7:0] cs, input int ex);
        logic [7:0] s [6] = '{8'hfa, 8'h02, 8'h00, cs, 8'h12, 8'h34};
        int r0;
        int e0;
        r0 = n_ram;
        e0 = n_exec;
        foreach (s[i]) snd(s[i]);
        repeat (4) @(posedge clk);
        check(n_ram - r0 === 2 && n_exec - e0 === ex && bad_wr === 0, "download run");
    endtask : t_load

    task automatic give_verdict;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #3000000;
        errors++;
        give_verdict();
    end

    initial begin
        {reset_n, flash_blank, op_error} = '0;
        id_code = 56'h71_62_53_44_35_26_17;
        repeat (20) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge clk);
        stat(8'h80, 8'h00);
        t_refuse();
        t_version();
        t_id(8'h00, 8'h04);
        t_id(id_code[7:0], 8'h0c);
        t_read(8'hff, 8'h01);
        t_read(8'hfc, 8'h0f);
        t_prog();
        t_erase();
        t_load(8'h00, 0);
        t_load(8'h46, 1);
        give_verdict();
    end
endmodule : tb

`default_nettype wire
